// *** bench/ciq_host_model.sv ***
`timescale 1ns/1ns
module ciq_host_model (
  input wire logic core_clk_i,
  input wire logic [7:0] reg_rdata_i,
  input wire logic reg_rvalid_i,
  output logic [5:0] reg_addr_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [7:0] reg_wdata_o
);
  initial begin
    reg_addr_o = 6'h2a;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_wdata_o = 8'h5a;
  end
  // idle bus shows the inverse of the last value, so a stale sample cannot pass
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    reg_addr_o <= a;
    reg_wdata_o <= d;
    reg_wr_o <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_o <= 1'b0;
    reg_addr_o <= ~a;
    reg_wdata_o <= ~d;
  endtask
  // bit 7 picks set or clear for the marked request bits
  task automatic req_update(input logic [5:0] a, input logic set, input logic [6:0] marks);
    wr(a, {set, marks});
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] d, output logic ok);
    int n;
    @(posedge core_clk_i);
    reg_addr_o <= a;
    reg_rd_o <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~a;
    #1;
    n = 0;
    while (reg_rvalid_i !== 1'b1 && n < 4) begin
      @(posedge core_clk_i);
      #1;
      n++;
    end
    ok = (reg_rvalid_i === 1'b1);
    d = reg_rdata_i;
  endtask
endmodule

// *** bench/command_and_irq_enable_regs_tb_top.sv ***
`timescale 1ns/1ns
module command_and_irq_enable_regs_tb_top;
  logic core_clk_i, rst_n_i, reg_wr_i, reg_rd_i, reg_rvalid_o, cmd_done_i, tx_done_i, rx_done_i;
  logic high_alert_i, low_alert_i, fault_i, timer_i, checksum_done_i, external_modulation_input_i;
  logic cmd_start_o, receiver_analog_off_o, soft_sleep_o, irq_o, irq_oe_o;
  logic [5:0] reg_addr_i;
  logic [7:0] reg_wdata_i, reg_rdata_o;
  logic [3:0] cmd_code_o;
  int err_count, compares;
  integer seed;

  // short wake and a known soft reset code keep the sleep and lockout cases reachable
  ciq_regs_top #(.WAKE_CYCLES(2), .VALID_CMD_MASK(16'h80ff)) u_dut (
    .core_clk_i, .rst_n_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o,
    .cmd_done_i, .tx_done_i, .rx_done_i, .high_alert_i, .low_alert_i, .fault_i, .timer_i, .checksum_done_i,
    .external_modulation_input_i, .cmd_code_o, .cmd_start_o, .receiver_analog_off_o, .soft_sleep_o,
    .irq_o, .irq_oe_o);
  ciq_host_model u_host (.core_clk_i, .reg_rdata_i(reg_rdata_o), .reg_rvalid_i(reg_rvalid_o),
    .reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i), .reg_wdata_o(reg_wdata_i));

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    u_host.rd(a, d, ok);
    if (ok !== 1'b1) begin
      err_count++;
      $display("[ERR] read answer expected 1 seen 0");
      print_verdict();
    end else begin
      chk($sformatf("reg %h", a), exp, d);
    end
  endtask
  // {oe, value}: open drain only ever pulls low, released means high
  function automatic logic [1:0] exp_pin(input logic [6:0] pri, input logic [7:0] sec,
                                         input logic [7:0] en1, input logic [7:0] en2);
    logic lvl;
    lvl = ((|(pri & en1[6:0])) | (|(sec & en2 & 8'h14))) ^ en1[7];
    return en2[7] ? {1'b1, lvl} : {~lvl, 1'b0};
  endfunction

  initial begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end
  initial begin
    #5000000;
    err_count++;
    $display("[ERR] run time expected below limit seen limit");
    print_verdict();
  end
  initial begin
    logic [7:0] hw, sw1, sw2, en1, en2, r, sec;
    logic [6:0] pri;
    logic known;
    seed = 32'h8ff6a554;
    err_count = 0;
    compares = 0;
    rst_n_i = 1'b0;
    cmd_done_i = 1'b0;
    {tx_done_i, rx_done_i, high_alert_i, low_alert_i, fault_i, timer_i} = 6'h00;
    checksum_done_i = 1'b0;
    external_modulation_input_i = 1'b0;
    repeat (3) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    #1;
    chk("pin oe", 8'h00, {7'h0, irq_oe_o});
    chk("rcv off", 8'h01, {7'h0, receiver_analog_off_o});
    rd_chk(6'h00, 8'h00);
    rd_chk(6'h01, 8'h20);
    rd_chk(6'h02, 8'h80);
    rd_chk(6'h03, 8'h00);
    rd_chk(6'h3f, 8'h00);
    r = 8'($random(seed));
    u_host.wr(6'h00, r);
    rd_chk(6'h00, 8'h00);
    u_host.wr(6'h03, 8'hff);
    rd_chk(6'h03, 8'h94);
    $display("test reset and access done");
    u_host.req_update(6'h04, 1'b0, 7'h7f);
    for (int i = 0; i < 16; i++) begin
      r = 8'($random(seed));
      known = (i < 8) || (i == 15);
      u_host.req_update(6'h04, 1'b0, 7'h10);
      u_host.wr(6'h01, {r[7:5], 1'b0, 4'(i)});
      #1;
      chk("start", {7'h0, known}, {7'h0, cmd_start_o});
      chk("code", {4'h0, known ? 4'(i) : 4'h0}, {4'h0, cmd_code_o});
      chk("rcv off", {7'h0, r[5]}, {7'h0, receiver_analog_off_o});
      rd_chk(6'h01, {2'b00, r[5], 1'b0, known ? 4'(i) : 4'h0});
      rd_chk(6'h04, known ? 8'h00 : 8'h10);
    end
    u_host.wr(6'h01, 8'h1f);
    #1;
    chk("sleep", 8'h00, {7'h0, soft_sleep_o});
    rd_chk(6'h01, 8'h0f);
    u_host.req_update(6'h04, 1'b0, 7'h7f);
    @(posedge core_clk_i);
    cmd_done_i <= 1'b1;
    @(posedge core_clk_i);
    cmd_done_i <= 1'b0;
    rd_chk(6'h01, 8'h00);
    rd_chk(6'h04, 8'h10);
    u_host.wr(6'h01, 8'h13);
    #1;
    chk("sleep", 8'h01, {7'h0, soft_sleep_o});
    u_host.wr(6'h01, 8'h03);
    #1;
    chk("sleep", 8'h00, {7'h0, soft_sleep_o});
    rd_chk(6'h01, 8'h13);
    repeat (6) @(posedge core_clk_i);
    rd_chk(6'h01, 8'h03);
    u_host.wr(6'h01, 8'h00);
    $display("test command done");
    for (int i = 0; i < 12; i++) begin
      hw = 8'($random(seed));
      sw1 = 8'($random(seed));
      sw2 = 8'($random(seed));
      en1 = (i == 0) ? 8'h80 : 8'($random(seed));
      en2 = (i == 0) ? 8'h00 : 8'($random(seed));
      u_host.req_update(6'h04, 1'b0, 7'h7f);
      u_host.req_update(6'h05, 1'b0, 7'h7f);
      @(posedge core_clk_i);
      {tx_done_i, rx_done_i, high_alert_i, low_alert_i, fault_i, timer_i} <= {hw[6:5], hw[3:0]};
      checksum_done_i <= hw[7];
      if (hw[4]) external_modulation_input_i <= ~external_modulation_input_i;
      @(posedge core_clk_i);
      {tx_done_i, rx_done_i, high_alert_i, low_alert_i, fault_i, timer_i} <= 6'h00;
      checksum_done_i <= 1'b0;
      u_host.req_update(6'h04, 1'b1, sw1[6:0]);
      u_host.req_update(6'h05, 1'b1, sw2[6:0]);
      pri = sw1[6:0] | (hw[6:0] & 7'h6f);
      sec = (sw2 | {3'b000, hw[4], 1'b0, hw[7], 2'b00}) & 8'h14;
      u_host.wr(6'h02, en1);
      u_host.wr(6'h03, en2);
      rd_chk(6'h04, {1'b0, pri});
      rd_chk(6'h05, sec);
      rd_chk(6'h02, en1);
      rd_chk(6'h03, en2 & 8'h94);
      r = {6'h00, exp_pin(pri, sec, en1, en2 & 8'h94)};
      chk("pin", r, {6'h00, irq_oe_o, irq_o});
    end
    // timer event held across a clear write: the set must survive
    @(posedge core_clk_i);
    timer_i <= 1'b1;
    u_host.req_update(6'h04, 1'b0, 7'h7f);
    timer_i <= 1'b0;
    rd_chk(6'h04, 8'h01);
    u_host.req_update(6'h04, 1'b0, 7'h7f);
    u_host.req_update(6'h05, 1'b0, 7'h7f);
    rd_chk(6'h04, 8'h00);
    rd_chk(6'h05, 8'h00);
    $display("test interrupt pin done");
    print_verdict();
  end
endmodule

// *** verilog/ciq_edge_detect.sv ***
`timescale 1ns/1ns
module ciq_edge_detect (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic level_i,
  output logic edge_o
);
  logic prev;
  logic armed;

  // no edge reported until one sample is held, so a high level at reset is not an edge
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      prev <= 1'b0;
      armed <= 1'b0;
    end else begin
      prev <= level_i;
      armed <= 1'b1;
    end
  end

  assign edge_o = armed && (prev != level_i); // RL17

  a_edge_found: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RL17
    ($past(armed) && armed && $changed(level_i)) |-> edge_o)
    else $error("input edge not reported");
endmodule

// *** verilog/ciq_pkg.sv ***
// Summary of operation
// RL1 - address 00h is reserved, all eight bits read zero, reset value zero.
// RL2 - command register sits at 01h, resets to 20h, top two bits reserved.
// RL3 - receiver-off bit 5 switches off the receiver analog part; read/write.
// RL4 - writing 1 to bit 4 of the command register enters soft power-down.
// RL5 - after bit 4 clears, wake-up runs; bit reads 1 until device is ready.
// RL6 - setting power-down is ignored while the soft reset command is active.
// RL7 - writing bits 3:0 starts that command; reading returns the running command.
// RL8 - primary enable register sits at 02h, resets to 80h, all bits read/write.
// RL9 - invert bit 7 set drives the pin inverted from the interrupt status bit.
// RL10 - invert at 1 with open-drain select at reset leaves the pin three-state.
// RL11 - primary enable bits 6:0 pass transmit, receive, idle, alerts, error, timer.
// RL12 - secondary enable register at 03h resets to 00h; bits 6:5, 3, 1:0 reserved.
// RL13 - drive select bit 7 set gives a push-pull pin, clear gives open-drain.
// RL14 - secondary bit 4 passes the external-input activity request to the pin.
// RL15 - secondary bit 2 passes the checksum-complete request to the pin.
// RL16 - request register writes: bit 7 high sets marked bits, low clears them.
// RL17 - any rising or falling edge on the external input sets its request.
// RL18 - an unknown command returns the field to idle and sets the idle request.
// RL19 - interrupt status is the OR of every request ANDed with its enable.
package ciq_pkg;
  localparam logic [5:0] ADDR_RSVD = 6'h00;
  localparam logic [5:0] ADDR_CMD = 6'h01;
  localparam logic [5:0] ADDR_PRI_EN = 6'h02;
  localparam logic [5:0] ADDR_SEC_EN = 6'h03;
  localparam logic [5:0] ADDR_PRI_REQ = 6'h04;
  localparam logic [5:0] ADDR_SEC_REQ = 6'h05;

  localparam logic [7:0] RST_RSVD = 8'h00;
  localparam logic [7:0] RST_CMD = 8'h20;
  localparam logic [7:0] RST_PRI_EN = 8'h80;
  localparam logic [7:0] RST_SEC_EN = 8'h00;
  localparam logic [6:0] RST_PRI_REQ = 7'h14;
  localparam logic [7:0] RST_SEC_REQ = 8'h00;

  localparam int CMD_RCV_OFF_BIT = 5;
  localparam int CMD_SLEEP_BIT = 4;
  localparam int CMD_CODE_MSB = 3;
  localparam int INVERT_BIT = 7;
  localparam int DRIVE_SEL_BIT = 7;
  localparam int SET_SEL_BIT = 7;
  localparam int IDLE_REQ_BIT = 4;
  localparam int EXT_ACT_BIT = 4;
  localparam int CRC_DONE_BIT = 2;
  // writable and readable bits of the secondary registers
  localparam logic [7:0] SEC_EN_MASK = 8'h94;
  localparam logic [7:0] SEC_REQ_MASK = 8'h14;

  typedef enum logic [2:0] {
    PWR_ACTIVE = 3'b001,
    PWR_SLEEP = 3'b010,
    PWR_WAKE = 3'b100
  } ciq_pwr_state_t;
endpackage

// *** verilog/ciq_regs_top.sv ***
`timescale 1ns/1ns
module ciq_regs_top #(
  parameter int WAKE_CYCLES = 16,
  parameter logic [15:0] VALID_CMD_MASK = 16'h00ff,
  parameter logic [3:0] CMD_IDLE = 4'h0,
  parameter logic [3:0] CMD_SOFT_RESET = 4'hf
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [5:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  input wire logic cmd_done_i,
  input wire logic tx_done_i,
  input wire logic rx_done_i,
  input wire logic high_alert_i,
  input wire logic low_alert_i,
  input wire logic fault_i,
  input wire logic timer_i,
  input wire logic checksum_done_i,
  input wire logic external_modulation_input_i,
  output logic [3:0] cmd_code_o,
  output logic cmd_start_o,
  output logic receiver_analog_off_o,
  output logic soft_sleep_o,
  output logic irq_o,
  output logic irq_oe_o
);
  function automatic logic cmd_known(input logic [3:0] code);
    cmd_known = VALID_CMD_MASK[code];
  endfunction

  function automatic logic hit(input logic [5:0] a, input logic [5:0] b);
    hit = (a == b);
  endfunction

  ciq_pkg::ciq_pwr_state_t pwr_state;
  ciq_pkg::ciq_pwr_state_t next_pwr_state;
  logic [3:0] cmd_code;
  logic receiver_analog_off;
  logic [7:0] pri_en;
  logic [7:0] sec_en;
  logic [6:0] pri_req;
  logic [7:0] sec_req;
  logic wr_cmd;
  logic wr_pri_req;
  logic wr_sec_req;
  logic ext_edge;
  logic wake_done;
  logic wake_start;
  logic idle_set;
  logic [6:0] pri_hw_set;
  logic [7:0] sec_hw_set;
  logic irq_status;
  logic pin_level;
  logic [7:0] cmd_readback;

  assign wr_cmd = reg_wr_i && hit(reg_addr_i, ciq_pkg::ADDR_CMD);
  assign wr_pri_req = reg_wr_i && hit(reg_addr_i, ciq_pkg::ADDR_PRI_REQ);
  assign wr_sec_req = reg_wr_i && hit(reg_addr_i, ciq_pkg::ADDR_SEC_REQ);

  ciq_edge_detect u_edge (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .level_i(external_modulation_input_i),
    .edge_o(ext_edge)
  );

  assign wake_start = (pwr_state == ciq_pkg::PWR_SLEEP) && wr_cmd && !reg_wdata_i[ciq_pkg::CMD_SLEEP_BIT];

  ciq_wake_timer #(
    .WAKE_CYCLES(WAKE_CYCLES)
  ) u_wake (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .start_i(wake_start),
    .done_o(wake_done)
  );

  // command field and receiver shut-off
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cmd_code <= ciq_pkg::RST_CMD[ciq_pkg::CMD_CODE_MSB:0];
      receiver_analog_off <= ciq_pkg::RST_CMD[ciq_pkg::CMD_RCV_OFF_BIT];
      cmd_start_o <= 1'b0;
    end else begin
      cmd_start_o <= 1'b0;
      if (wr_cmd) begin
        receiver_analog_off <= reg_wdata_i[ciq_pkg::CMD_RCV_OFF_BIT]; // RL3
        if (cmd_known(reg_wdata_i[ciq_pkg::CMD_CODE_MSB:0])) begin
          cmd_code <= reg_wdata_i[ciq_pkg::CMD_CODE_MSB:0]; // RL7
          cmd_start_o <= 1'b1;
        end else begin
          cmd_code <= CMD_IDLE; // RL18
        end
      end else if (cmd_done_i && cmd_code != CMD_IDLE) begin
        cmd_code <= CMD_IDLE; // RL7
      end
    end
  end

  // host starting idle does not raise the idle request; a command ending does
  assign idle_set = (wr_cmd && !cmd_known(reg_wdata_i[ciq_pkg::CMD_CODE_MSB:0])) // RL18
    || (!wr_cmd && cmd_done_i && cmd_code != CMD_IDLE);

  // soft power-down sequencing
  always_comb begin
    next_pwr_state = pwr_state;
    case (pwr_state)
      ciq_pkg::PWR_ACTIVE: begin
        if (wr_cmd && reg_wdata_i[ciq_pkg::CMD_SLEEP_BIT] && cmd_code != CMD_SOFT_RESET) begin // RL6
          next_pwr_state = ciq_pkg::PWR_SLEEP; // RL4
        end
      end
      ciq_pkg::PWR_SLEEP: begin
        if (wake_start) begin
          next_pwr_state = ciq_pkg::PWR_WAKE; // RL5
        end
      end
      ciq_pkg::PWR_WAKE: begin
        if (wake_done) begin
          next_pwr_state = ciq_pkg::PWR_ACTIVE; // RL5
        end
      end
      default: begin
        next_pwr_state = ciq_pkg::PWR_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      pwr_state <= ciq_pkg::PWR_ACTIVE;
    end else begin
      pwr_state <= next_pwr_state;
    end
  end

  // enable registers
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      pri_en <= ciq_pkg::RST_PRI_EN; // RL8
      sec_en <= ciq_pkg::RST_SEC_EN; // RL12
    end else if (reg_wr_i && hit(reg_addr_i, ciq_pkg::ADDR_PRI_EN)) begin
      pri_en <= reg_wdata_i; // RL8
    end else if (reg_wr_i && hit(reg_addr_i, ciq_pkg::ADDR_SEC_EN)) begin
      sec_en <= reg_wdata_i & ciq_pkg::SEC_EN_MASK; // RL12
    end
  end

  // request bits: hardware set wins over a clear in the same cycle
  assign pri_hw_set = {tx_done_i, rx_done_i, idle_set, high_alert_i, low_alert_i, fault_i, timer_i};
  assign sec_hw_set = {3'h0, ext_edge, 1'b0, checksum_done_i, 2'h0} & ciq_pkg::SEC_REQ_MASK; // RL17

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      pri_req <= ciq_pkg::RST_PRI_REQ;
    end else if (wr_pri_req && reg_wdata_i[ciq_pkg::SET_SEL_BIT]) begin
      pri_req <= pri_req | reg_wdata_i[6:0] | pri_hw_set; // RL16
    end else if (wr_pri_req) begin
      pri_req <= (pri_req & ~reg_wdata_i[6:0]) | pri_hw_set; // RL16
    end else begin
      pri_req <= pri_req | pri_hw_set;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      sec_req <= ciq_pkg::RST_SEC_REQ;
    end else if (wr_sec_req && reg_wdata_i[ciq_pkg::SET_SEL_BIT]) begin
      sec_req <= sec_req | (reg_wdata_i & ciq_pkg::SEC_REQ_MASK) | sec_hw_set; // RL16
    end else if (wr_sec_req) begin
      sec_req <= (sec_req & ~reg_wdata_i) | sec_hw_set; // RL16
    end else begin
      sec_req <= sec_req | sec_hw_set;
    end
  end

  // pin logic
  assign irq_status = |(pri_req & pri_en[6:0]) // RL11 RL19
    || (sec_req[ciq_pkg::EXT_ACT_BIT] && sec_en[ciq_pkg::EXT_ACT_BIT]) // RL14
    || (sec_req[ciq_pkg::CRC_DONE_BIT] && sec_en[ciq_pkg::CRC_DONE_BIT]); // RL15
  assign pin_level = irq_status ^ pri_en[ciq_pkg::INVERT_BIT]; // RL9

  // open-drain only pulls low, so a high level releases the pin
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      irq_o <= 1'b0;
      irq_oe_o <= 1'b0; // RL10
    end else if (sec_en[ciq_pkg::DRIVE_SEL_BIT]) begin
      irq_o <= pin_level; // RL13
      irq_oe_o <= 1'b1;
    end else begin
      irq_o <= 1'b0; // RL13
      irq_oe_o <= !pin_level; // RL10
    end
  end

  // read path, one cycle after the strobe
  assign cmd_readback = {2'h0, receiver_analog_off, pwr_state != ciq_pkg::PWR_ACTIVE, cmd_code}; // RL2 RL5

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (!reg_rd_i) begin
        reg_rdata_o <= 8'h00;
      end else if (hit(reg_addr_i, ciq_pkg::ADDR_RSVD)) begin
        reg_rdata_o <= ciq_pkg::RST_RSVD; // RL1
      end else if (hit(reg_addr_i, ciq_pkg::ADDR_CMD)) begin
        reg_rdata_o <= cmd_readback; // RL7
      end else if (hit(reg_addr_i, ciq_pkg::ADDR_PRI_EN)) begin
        reg_rdata_o <= pri_en;
      end else if (hit(reg_addr_i, ciq_pkg::ADDR_SEC_EN)) begin
        reg_rdata_o <= sec_en;
      end else if (hit(reg_addr_i, ciq_pkg::ADDR_PRI_REQ)) begin
        reg_rdata_o <= {1'b0, pri_req};
      end else if (hit(reg_addr_i, ciq_pkg::ADDR_SEC_REQ)) begin
        reg_rdata_o <= sec_req;
      end else begin
        reg_rdata_o <= 8'h00;
      end
    end
  end

  assign cmd_code_o = cmd_code;
  assign receiver_analog_off_o = receiver_analog_off;
  assign soft_sleep_o = (pwr_state == ciq_pkg::PWR_SLEEP);

  a_rsvd_reads_zero: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RL1
    (reg_rd_i && reg_addr_i == ciq_pkg::ADDR_RSVD) |=> (reg_rvalid_o && reg_rdata_o == 8'h00))
    else $error("reserved slot read nonzero");

  a_cmd_top_zero: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RL2
    (reg_rd_i && reg_addr_i == ciq_pkg::ADDR_CMD) |=> reg_rdata_o[7:6] == 2'h0)
    else $error("command top bits not zero");

  a_rcv_off_write: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RL3
    wr_cmd |=> receiver_analog_off_o == $past(reg_wdata_i[ciq_pkg::CMD_RCV_OFF_BIT]))
    else $error("receiver off bit not stored");

  a_sleep_entry: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RL4
    (pwr_state == ciq_pkg::PWR_ACTIVE && wr_cmd && reg_wdata_i[ciq_pkg::CMD_SLEEP_BIT]
      && cmd_code != CMD_SOFT_RESET) |=> soft_sleep_o)
    else $error("power-down not entered");

  a_sleep_blocked: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RL6
    (pwr_state == ciq_pkg::PWR_ACTIVE && cmd_code == CMD_SOFT_RESET) |=> !soft_sleep_o)
    else $error("power-down set during soft reset");

  a_wake_reads_one: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RL5
    $fell(soft_sleep_o) |-> (pwr_state == ciq_pkg::PWR_WAKE && cmd_readback[4]) [*2])
    else $error("wake-up did not read as one");

  a_unknown_cmd: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RL18
    (wr_cmd && !cmd_known(reg_wdata_i[ciq_pkg::CMD_CODE_MSB:0]))
      |=> (cmd_code_o == CMD_IDLE && pri_req[ciq_pkg::IDLE_REQ_BIT] && !cmd_start_o))
    else $error("unknown command not turned idle");

  a_pin_push_pull: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RL9
    sec_en[ciq_pkg::DRIVE_SEL_BIT]
      |=> (irq_oe_o && irq_o == ($past(irq_status) ^ $past(pri_en[ciq_pkg::INVERT_BIT]))))
    else $error("push-pull pin level wrong");

  a_pin_open_drain: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RL13
    !sec_en[ciq_pkg::DRIVE_SEL_BIT]
      |=> (!irq_o && irq_oe_o == ($past(irq_status) == $past(pri_en[ciq_pkg::INVERT_BIT]))))
    else $error("open-drain pin drive wrong");

  a_req_set_wins: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RL16
    (wr_pri_req && !reg_wdata_i[ciq_pkg::SET_SEL_BIT] && timer_i) |=> pri_req[0])
    else $error("hardware set lost to clear");
endmodule

// *** verilog/ciq_wake_timer.sv ***
`timescale 1ns/1ns
module ciq_wake_timer #(
  parameter int WAKE_CYCLES = 16
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  output logic done_o
);
  localparam int CW = $clog2(WAKE_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(WAKE_CYCLES - 1);
  logic [CW-1:0] count;
  logic running;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      count <= '0;
      running <= 1'b0;
    end else if (start_i) begin
      count <= '0;
      running <= 1'b1;
    end else if (running) begin
      count <= count + CW'(1);
      if (count == LAST) begin
        running <= 1'b0;
      end
    end
  end

  assign done_o = running && (count == LAST); // RL5

  a_wake_length: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // RL5
    start_i |-> !done_o ##1 (running && count == '0))
    else $error("wake count did not restart");
endmodule
